/* File: logic/smdf_defs.svh */
`ifndef SMDF_DEFS_SVH
`define SMDF_DEFS_SVH
// ====
// command codes on cmd_op
`define SMDF_OP_ASCII 4'h0
`define SMDF_OP_WIDE 4'h1
`define SMDF_OP_INT 4'h2
`define SMDF_OP_FLOAT 4'h3
`define SMDF_OP_RAW 4'h4
`define SMDF_OP_REGS 4'h5
`define SMDF_OP_ARRAY 4'h6
`define SMDF_OP_FILE 4'h7
`define SMDF_OP_RXHOST 4'h8
`define SMDF_OP_RXTEXT 4'h9
`define SMDF_OP_RXWTEXT 4'ha
`define SMDF_OP_RXREG 4'hb
`define SMDF_OP_RXARR 4'hc
// ====
// interface select on cmd_if
`define SMDF_IF_SERIAL 2'h0
`define SMDF_IF_SPI 2'h1
`define SMDF_IF_I2C 2'h2
// ====
// reply frame bytes
`define SMDF_HDR_ESC 8'h1b
`define SMDF_HDR_GRP 8'h48
`define SMDF_HDR_CMD 8'h52
`define SMDF_IFCH_SERIAL 8'h52
`define SMDF_IFCH_SPI 8'h53
`define SMDF_IFCH_I2C 8'h49
`define SMDF_HDR_LAST 3'h7
// ====
// count limits
`define SMDF_HOST_CAP 32'h00000400
`define SMDF_TEXT_CAP 32'h000000fa
// ====
// type codes
`define SMDF_T_S8 8'h07
`define SMDF_T_U8 8'h08
`define SMDF_T_S16 8'h0f
`define SMDF_T_U16 8'h10
`define SMDF_T_S24 8'h17
`define SMDF_T_U24 8'h18
`define SMDF_T_S32 8'h1f
`define SMDF_T_U32 8'h20
`define SMDF_T_FLT 8'h21
`define SMDF_T_BIG_OFS 8'h64
`endif

/* File: logic/smdf_pkg.sv */
package smdf_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_FETCH, S_LOAD, S_SEND, S_HDR, S_WAITRX, S_RECV,
        S_HOST, S_STORE, S_DONE
    } smdf_state_e;

    typedef struct packed {
        logic ok;
        logic big;
        logic sgn;
        logic [1:0] wlast;
    } smdf_fmt_s;
endpackage

/* File: logic/smdf_top.sv */
`timescale 1ns/10ps
`include "smdf_defs.svh"
// Notes on behaviour
// R1: ascii send emits each character or code as one byte.
// R2: wide-character send emits each character or code as 16 bits.
// R3: integer send emits each value as 32-bit two's complement, low byte first.
// R4: float send emits each value as 32-bit float, low byte first.
// R5: raw send forwards the stated number of bytes untouched.
// R6: register send emits count register entries encoded by type code.
// R7: array send emits count elements from start index, encoded by type.
// R8: types 7/8,15/16,23/24,31/32 little endian ints; 33 float.
// R9: types 115..132 big endian ints; 133 big endian float.
// R10: file send streams the whole stored file out.
// R11: receive to host copies up to 1024 received bytes to send buffer.
// R12: reply frame is 1b,48,interface byte,52,32-bit length,data.
// R13: byte receive fills string register with up to 250 bytes.
// R14: word receive fills string register with up to 250 16-bit chars.
// R15: receive to register decodes count values by type; count defaults one.
// R16: receive to array needs the array defined beforehand.
// R17: after any such command the interface acts only as master.
// R18: interface select picks serial, spi or i2c; formatting identical.
// R19: receive stalls until the receive buffer holds enough bytes.
module smdf_top (
    input wire logic sys_clk, // 20 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic cmd_valid, // command offered
    input wire logic [3:0] cmd_op, // command code
    input wire logic [1:0] cmd_if, // interface select
    input wire logic [7:0] cmd_type, // type code
    input wire logic [7:0] cmd_id, // register, array, string or file id
    input wire logic [15:0] cmd_start, // array start index
    input wire logic [31:0] cmd_count, // element count
    input wire logic dest_defined, // target array exists
    output logic cmd_ready, // idle, command accepted
    output logic busy, // command in progress
    output logic done, // command finished pulse
    output logic error, // error flag with done
    output logic fetch_req, // element read strobe
    output logic [7:0] fetch_id, // element source id
    output logic [15:0] fetch_index, // element index
    input wire logic [31:0] fetch_data, // element, cycle after fetch_req
    input wire logic fetch_last, // last byte of file
    output logic tx_valid, // byte to master interface
    output logic [7:0] tx_byte, // byte value
    output logic [1:0] tx_if, // interface carrying the byte
    input wire logic tx_ready, // master interface takes byte
    input wire logic rx_valid, // received byte present
    input wire logic [7:0] rx_byte, // received byte
    input wire logic [10:0] rx_count, // bytes held in receive buffer
    output logic rx_ready, // received byte consumed
    output logic host_valid, // byte to host send buffer
    output logic [7:0] host_byte, // byte value
    input wire logic host_ready, // send buffer takes byte
    output logic store_valid, // write strobe
    output logic [7:0] store_id, // destination id
    output logic [15:0] store_index, // destination index
    output logic [31:0] store_data, // decoded value
    output logic [2:0] master_mode // per interface master only
);
    // ====
    // format helpers
    function automatic smdf_pkg::smdf_fmt_s decode_type(input logic [7:0] t);
        smdf_pkg::smdf_fmt_s f;
        logic [7:0] b;
        f = '0;
        b = t;
        // R9: big endian family
        if (t > `SMDF_T_BIG_OFS) begin
            f.big = 1'b1;
            b = t - `SMDF_T_BIG_OFS;
        end
        f.ok = 1'b1;
        // R8: width and sign per code
        unique case (b)
            `SMDF_T_S8: {f.sgn, f.wlast} = 3'h4;
            `SMDF_T_U8: {f.sgn, f.wlast} = 3'h0;
            `SMDF_T_S16: {f.sgn, f.wlast} = 3'h5;
            `SMDF_T_U16: {f.sgn, f.wlast} = 3'h1;
            `SMDF_T_S24: {f.sgn, f.wlast} = 3'h6;
            `SMDF_T_U24: {f.sgn, f.wlast} = 3'h2;
            `SMDF_T_S32: {f.sgn, f.wlast} = 3'h7;
            `SMDF_T_U32, `SMDF_T_FLT: {f.sgn, f.wlast} = 3'h3;
            default: f.ok = 1'b0;
        endcase
        // single byte codes have no big endian form
        if (f.big && f.wlast == 2'h0) begin
            f.ok = 1'b0;
        end
        return f;
    endfunction

    function automatic logic [7:0] byte_of(input logic [31:0] w,
            input logic [1:0] k, input logic [1:0] wl, input logic big);
        logic [1:0] p;
        p = big ? wl - k : k;
        return w[{p, 3'h0} +: 8];
    endfunction

    function automatic logic [31:0] extend(input logic [31:0] w,
            input logic [1:0] wl, input logic s);
        logic [31:0] r;
        r = w;
        unique case (wl)
            2'h0: r = {{24{s & w[7]}}, w[7:0]};
            2'h1: r = {{16{s & w[15]}}, w[15:0]};
            2'h2: r = {{8{s & w[23]}}, w[23:0]};
            2'h3: r = w;
        endcase
        return r;
    endfunction

    // ====
    // state
    smdf_pkg::smdf_state_e state, next_state;
    smdf_pkg::smdf_fmt_s fmt, next_fmt;
    logic [3:0] op, next_op;
    logic [1:0] next_tx_if;
    logic [7:0] next_fetch_id;
    logic [15:0] next_fetch_index;
    logic [31:0] remain, next_remain, word, next_word, len, next_len;
    logic [1:0] bidx, next_bidx;
    logic [2:0] hidx, next_hidx;
    logic [2:0] next_master_mode;
    logic [7:0] next_tx_byte, next_host_byte, ifch;
    logic next_error;
    logic elem_end;

    always_comb begin
        unique case (tx_if)
            `SMDF_IF_SPI: ifch = `SMDF_IFCH_SPI;
            `SMDF_IF_I2C: ifch = `SMDF_IFCH_I2C;
            default: ifch = `SMDF_IFCH_SERIAL;
        endcase
    end

    // ====
    // command sequencer
    always_comb begin
        next_state = state;
        next_fmt = fmt;
        next_op = op;
        next_tx_if = tx_if;
        next_fetch_id = fetch_id;
        next_fetch_index = fetch_index;
        next_remain = remain;
        next_word = word;
        next_len = len;
        next_bidx = bidx;
        next_hidx = hidx;
        next_master_mode = master_mode;
        next_error = error;
        next_tx_byte = tx_byte;
        next_host_byte = host_byte;
        elem_end = 1'b0;
        unique case (state)
            smdf_pkg::S_IDLE: if (cmd_valid) begin
                next_op = cmd_op;
                // R18: one interface per command, same formatting
                next_tx_if = cmd_if;
                // R17: interface turns master for good
                next_master_mode[cmd_if] = 1'b1;
                next_fetch_id = cmd_id;
                next_fetch_index = 16'h0000;
                next_remain = cmd_count;
                next_bidx = 2'h0;
                next_hidx = 3'h0;
                next_word = 32'h0;
                next_error = 1'b0;
                next_fmt = '{ok: 1'b1, big: 1'b0, sgn: 1'b0, wlast: 2'h0};
                next_state = (cmd_count == 32'h0) ? smdf_pkg::S_DONE
                                                   : smdf_pkg::S_FETCH;
                unique case (cmd_op)
                    // R1 R5 R10: byte wide, no interpretation
                    `SMDF_OP_ASCII, `SMDF_OP_RAW: ;
                    `SMDF_OP_FILE: next_state = smdf_pkg::S_FETCH;
                    // R2: 16-bit characters
                    `SMDF_OP_WIDE: next_fmt.wlast = 2'h1;
                    // R3: signed 32-bit, low byte first
                    `SMDF_OP_INT: {next_fmt.sgn, next_fmt.wlast} = 3'h7;
                    // R4: float word, low byte first
                    `SMDF_OP_FLOAT: next_fmt.wlast = 2'h3;
                    // R6 R15: typed, count defaults to one
                    `SMDF_OP_REGS, `SMDF_OP_RXREG: begin
                        next_fmt = decode_type(cmd_type);
                        if (cmd_count == 32'h0) begin
                            next_remain = 32'h1;
                        end
                        next_state = (cmd_op == `SMDF_OP_REGS)
                            ? smdf_pkg::S_FETCH : smdf_pkg::S_WAITRX;
                    end
                    // R7 R16: typed, from the start index
                    `SMDF_OP_ARRAY, `SMDF_OP_RXARR: begin
                        next_fmt = decode_type(cmd_type);
                        next_fetch_index = cmd_start;
                        if (cmd_op == `SMDF_OP_RXARR && cmd_count != 32'h0) begin
                            next_state = smdf_pkg::S_WAITRX;
                        end
                        // R16: undefined array is refused
                        if (cmd_op == `SMDF_OP_RXARR && !dest_defined) begin
                            next_fmt.ok = 1'b0;
                        end
                    end
                    // R11: capped byte count, header first
                    `SMDF_OP_RXHOST: begin
                        if (cmd_count > `SMDF_HOST_CAP) begin
                            next_remain = `SMDF_HOST_CAP;
                        end
                        next_state = smdf_pkg::S_HDR;
                    end
                    // R13 R14: text limited to 250 characters
                    `SMDF_OP_RXTEXT, `SMDF_OP_RXWTEXT: begin
                        next_fmt.wlast = (cmd_op == `SMDF_OP_RXWTEXT)
                            ? 2'h1 : 2'h0;
                        if (cmd_count > `SMDF_TEXT_CAP) begin
                            next_remain = `SMDF_TEXT_CAP;
                        end
                        if (cmd_count != 32'h0) begin
                            next_state = smdf_pkg::S_WAITRX;
                        end
                    end
                    default: next_fmt.ok = 1'b0;
                endcase
                next_len = next_remain;
                if (!next_fmt.ok) begin
                    next_error = 1'b1;
                    next_state = smdf_pkg::S_DONE;
                end
                next_host_byte = `SMDF_HDR_ESC;
            end
            smdf_pkg::S_FETCH: next_state = smdf_pkg::S_LOAD;
            smdf_pkg::S_LOAD: begin
                next_word = fetch_data;
                next_bidx = 2'h0;
                next_tx_byte = byte_of(fetch_data, 2'h0, fmt.wlast, fmt.big);
                next_state = smdf_pkg::S_SEND;
                next_remain = (op != `SMDF_OP_FILE) ? remain
                    : fetch_last ? 32'h1 : 32'h2;
            end
            smdf_pkg::S_SEND: if (tx_ready) begin
                if (bidx == fmt.wlast) begin
                    elem_end = 1'b1;
                end else begin
                    next_bidx = bidx + 2'h1;
                    next_tx_byte = byte_of(word, next_bidx, fmt.wlast,
                                           fmt.big);
                end
            end
            // R12: eight byte reply header then data
            smdf_pkg::S_HDR: if (host_ready) begin
                next_hidx = hidx + 3'h1;
                unique case (next_hidx)
                    3'h1: next_host_byte = `SMDF_HDR_GRP;
                    3'h2: next_host_byte = ifch;
                    3'h3: next_host_byte = `SMDF_HDR_CMD;
                    3'h4: next_host_byte = len[7:0];
                    3'h5: next_host_byte = len[15:8];
                    3'h6: next_host_byte = len[23:16];
                    3'h7: next_host_byte = len[31:24];
                    default: next_host_byte = `SMDF_HDR_ESC;
                endcase
                if (hidx == `SMDF_HDR_LAST) begin
                    next_state = (remain == 32'h0) ? smdf_pkg::S_DONE
                                                   : smdf_pkg::S_WAITRX;
                end
            end
            // R19: hold until the element's bytes are buffered
            smdf_pkg::S_WAITRX: begin
                next_word = 32'h0;
                next_bidx = 2'h0;
                if (rx_count > {9'h000, fmt.wlast}) begin
                    next_state = smdf_pkg::S_RECV;
                end
            end
            smdf_pkg::S_RECV: if (rx_valid) begin
                // R8 R9: reassemble in the coded byte order
                next_word = fmt.big ? {word[23:0], rx_byte}
                    : word | ({24'h0, rx_byte} << {bidx, 3'h0});
                next_host_byte = rx_byte;
                next_bidx = bidx + 2'h1;
                if (bidx == fmt.wlast) begin
                    next_state = (op == `SMDF_OP_RXHOST)
                        ? smdf_pkg::S_HOST : smdf_pkg::S_STORE;
                end
            end
            smdf_pkg::S_HOST: if (host_ready) begin
                elem_end = 1'b1;
            end
            smdf_pkg::S_STORE: elem_end = 1'b1;
            smdf_pkg::S_DONE: next_state = smdf_pkg::S_IDLE;
        endcase
        if (elem_end) begin
            next_remain = remain - 32'h1;
            next_fetch_index = fetch_index + 16'h0001;
            if (remain == 32'h1) begin
                next_state = smdf_pkg::S_DONE;
            end else if (state == smdf_pkg::S_SEND) begin
                next_state = smdf_pkg::S_FETCH;
            end else begin
                next_state = smdf_pkg::S_WAITRX;
            end
        end
    end

    // ====
    // registers; strobes mirror the coming state so they leave flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= smdf_pkg::S_IDLE;
            fmt <= '0;
            op <= 4'h0;
            tx_if <= 2'h0;
            fetch_id <= 8'h00;
            fetch_index <= 16'h0000;
            remain <= 32'h0;
            word <= 32'h0;
            len <= 32'h0;
            bidx <= 2'h0;
            hidx <= 3'h0;
            master_mode <= 3'h0;
            error <= 1'b0;
            tx_byte <= 8'h00;
            host_byte <= 8'h00;
            cmd_ready <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            fetch_req <= 1'b0;
            tx_valid <= 1'b0;
            rx_ready <= 1'b0;
            host_valid <= 1'b0;
            store_valid <= 1'b0;
            store_id <= 8'h00;
            store_index <= 16'h0000;
            store_data <= 32'h0;
        end else begin
            state <= next_state;
            fmt <= next_fmt;
            op <= next_op;
            tx_if <= next_tx_if;
            fetch_id <= next_fetch_id;
            fetch_index <= next_fetch_index;
            remain <= next_remain;
            word <= next_word;
            len <= next_len;
            bidx <= next_bidx;
            hidx <= next_hidx;
            master_mode <= next_master_mode;
            error <= next_error;
            tx_byte <= next_tx_byte;
            host_byte <= next_host_byte;
            cmd_ready <= next_state == smdf_pkg::S_IDLE;
            busy <= next_state != smdf_pkg::S_IDLE;
            done <= next_state == smdf_pkg::S_DONE;
            fetch_req <= next_state == smdf_pkg::S_FETCH;
            tx_valid <= next_state == smdf_pkg::S_SEND;
            rx_ready <= next_state == smdf_pkg::S_RECV;
            host_valid <= next_state == smdf_pkg::S_HDR
                || next_state == smdf_pkg::S_HOST;
            store_valid <= next_state == smdf_pkg::S_STORE;
            store_id <= next_fetch_id;
            store_index <= next_fetch_index;
            // R15: narrow values widened by sign
            store_data <= extend(next_word, fmt.wlast, fmt.sgn);
        end
    end
endmodule

/* File: tb/smdf_sva.sv */
`timescale 1ns/10ps
module smdf_sva (
    input wire logic sys_clk, // clock
    input wire logic arst_n, // reset, active low
    input wire logic cmd_valid, // command offered
    input wire logic cmd_ready, // idle
    input wire logic busy, // command running
    input wire logic done, // end pulse
    input wire logic error, // error flag
    input wire logic tx_valid, // byte offered
    input wire logic [7:0] tx_byte, // byte value
    input wire logic [1:0] tx_if, // carrying interface
    input wire logic tx_ready, // byte taken
    input wire logic rx_ready, // byte consumed
    input wire logic [10:0] rx_count, // bytes buffered
    input wire logic host_valid, // byte to host
    input wire logic [7:0] host_byte, // byte value
    input wire logic host_ready, // host takes byte
    input wire logic store_valid, // write strobe
    input wire logic [2:0] master_mode // master flags
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_take; cmd_valid && cmd_ready |=> !cmd_ready && busy; endproperty
    a_take: assert property (p_take) else $error("take not honoured");
    property p_done; done |=> !done && cmd_ready; endproperty
    a_done: assert property (p_done) else $error("done not one cycle");
    property p_err; $rose(error) |-> done; endproperty
    a_err: assert property (p_err) else $error("error without done");
    property p_busy; store_valid || tx_valid || host_valid |-> busy; endproperty
    a_busy: assert property (p_busy) else $error("moves while idle");
    property p_tx_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_if);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx dropped");
    property p_tx_if; tx_valid |-> tx_if != 2'h3; endproperty
    a_tx_if: assert property (p_tx_if) else $error("bad tx_if");
    property p_host_hold;
        host_valid && !host_ready |=> host_valid && $stable(host_byte);
    endproperty
    a_host_hold: assert property (p_host_hold) else $error("host dropped");
    property p_rx_wait; rx_ready |-> rx_count != 11'h000; endproperty
    a_rx_wait: assert property (p_rx_wait) else $error("read on empty");
    property p_sticky; ($past(master_mode) & ~master_mode) == 3'h0; endproperty
    a_sticky: assert property (p_sticky) else $error("master bit fell");
endmodule
bind smdf_top smdf_sva u_sva (.sys_clk, .arst_n, .cmd_valid, .cmd_ready,
    .busy, .done, .error, .tx_valid, .tx_byte, .tx_if, .tx_ready, .rx_ready,
    .rx_count, .host_valid, .host_byte, .host_ready, .store_valid,
    .master_mode);

/* File: tb/smdf_peer.sv */
`timescale 1ns/10ps
module smdf_peer (
    input wire logic sys_clk, // clock
    input wire logic arst_n, // reset, active low
    input wire logic tx_valid, // byte offered
    input wire logic [7:0] tx_byte, // byte value
    input wire logic [1:0] tx_if, // carrying interface
    output logic tx_ready, // byte taken
    output logic rx_valid, // byte present
    output logic [7:0] rx_byte, // byte value
    output logic [10:0] rx_count, // bytes buffered
    input wire logic rx_ready // byte consumed
);
    logic [9:0] txq[$];
    logic [7:0] rxq[$];
    integer seed = 32'h98dcadb4;
    integer r;
    // random ready adds stalls
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
            rx_count <= 11'h000;
        end else begin
            r = $random(seed);
            if (tx_valid && tx_ready)
                txq.push_back({tx_if, tx_byte});
            if (rx_valid && rx_ready)
                void'(rxq.pop_front());
            tx_ready <= r[0];
            rx_valid <= rxq.size() != 0;
            rx_byte <= rxq.size() != 0 ? rxq[0] : ~rx_byte;
            rx_count <= 11'(rxq.size());
        end
    end
endmodule

/* File: tb/smdf_top_test.sv */
`timescale 1ns/10ps
`include "smdf_defs.svh"
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        $display("Error %s expected %h seen %h", nm, e, g); \
        mismatches++; \
    end \
end
module smdf_top_test;
    logic sys_clk, arst_n, cmd_valid, dest_defined, fetch_last, late;
    logic [3:0] cmd_op;
    logic [1:0] cmd_if, tx_if;
    logic [7:0] cmd_type, cmd_id, fetch_id, tx_byte, rx_byte, host_byte;
    logic [7:0] store_id;
    logic [15:0] cmd_start, fetch_index, store_index;
    logic [31:0] cmd_count, fetch_data, store_data;
    logic [10:0] rx_count;
    logic [2:0] master_mode;
    logic cmd_ready, busy, done, error, fetch_req, tx_valid, tx_ready;
    logic rx_valid, rx_ready, host_valid, host_ready, store_valid;
    logic [9:0] expq[$];
    logic [55:0] exps[$], stq[$];
    logic [7:0] exph[$], hostq[$], lq[$];
    logic [7:0] tcode[16] = '{8'h07, 8'h08, 8'h0f, 8'h10, 8'h17, 8'h18,
        8'h1f, 8'h20, 8'h21, 8'h73, 8'h74, 8'h7b, 8'h7c, 8'h83, 8'h84, 8'h85};
    logic [3:0] tops[4] = '{4'h5, 4'h6, 4'hb, 4'hc};
    logic [15:0] flen = 16'h0006;
    integer seed = 32'h98dcadb4;
    int mismatches = 0;
    int tests_run = 0;
    int rr, j;
    smdf_top dut (.sys_clk, .arst_n, .cmd_valid, .cmd_op, .cmd_if, .cmd_type,
        .cmd_id, .cmd_start, .cmd_count, .dest_defined, .cmd_ready, .busy,
        .done, .error, .fetch_req, .fetch_id, .fetch_index, .fetch_data,
        .fetch_last, .tx_valid, .tx_byte, .tx_if, .tx_ready, .rx_valid,
        .rx_byte, .rx_count, .rx_ready, .host_valid, .host_byte, .host_ready,
        .store_valid, .store_id, .store_index, .store_data, .master_mode);
    smdf_peer peer (.sys_clk, .arst_n, .tx_valid, .tx_byte, .tx_if, .tx_ready,
        .rx_valid, .rx_byte, .rx_count, .rx_ready);
    function automatic logic [31:0] elem(logic [7:0] id, logic [15:0] ix);
        return {id ^ 8'ha5, ix[7:0], ix[15:8] ^ id, ix[7:0] ^ 8'h3c};
    endfunction
    function automatic int width(logic [7:0] t);
        return (int'(t > 8'h64 ? t - 8'h64 : t) + 1) / 8;
    endfunction
    // ====
    // element store and host buffer sides
    always @(posedge sys_clk) begin
        rr = $random(seed);
        host_ready <= rr[1];
        fetch_data <= fetch_req ? elem(fetch_id, fetch_index) : ~fetch_data;
        fetch_last <= fetch_req && fetch_index == flen - 16'h0001;
        if (host_valid && host_ready)
            hostq.push_back(host_byte);
        if (store_valid)
            stq.push_back({store_id, store_index, store_data});
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ====
    // one command with its expected traffic
    task automatic run(input logic [3:0] op, input logic [1:0] cif,
        input logic [7:0] typ, input logic [31:0] cnt, input logic df,
        input logic err);
        int w, n, b, i, k;
        logic big, sg;
        logic [7:0] id, by;
        logic [15:0] st, ix;
        logic [31:0] v;
        id = 8'($random(seed));
        st = 16'($random(seed));
        ix = (op == 4'h6 || op == 4'hc) ? st : 16'h0000;
        big = 1'b0;
        sg = 1'b0;
        case (op)
            4'h1, 4'ha: w = 2;
            4'h2, 4'h3: w = 4;
            4'h5, 4'h6, 4'hb, 4'hc: begin
                w = width(typ);
                big = typ > 8'h63;
                sg = typ[0] && w < 4;
            end
            default: w = 1;
        endcase
        n = (cnt == 0 && (op == 4'h5 || op == 4'hb)) ? 1 : int'(cnt);
        if (op == 4'h7) n = flen;
        if (op == 4'h9 || op == 4'ha) n = n > 250 ? 250 : n;
        if (op == 4'h8) n = n > 1024 ? 1024 : n;
        by = cif == 2'h0 ? `SMDF_IFCH_SERIAL :
            cif == 2'h1 ? `SMDF_IFCH_SPI : `SMDF_IFCH_I2C;
        if (!err && op == 4'h8) begin
            exph = '{`SMDF_HDR_ESC, `SMDF_HDR_GRP, by, `SMDF_HDR_CMD,
                n[7:0], n[15:8], n[23:16], n[31:24]};
            for (i = 0; i < n; i++) begin
                by = 8'($random(seed));
                lq.push_back(by);
                exph.push_back(by);
            end
        end else if (!err) begin
            for (i = 0; i < n; i++) begin
                v = op < 4'h8 ? elem(id, ix + 16'(i)) : 32'h0;
                for (b = 0; b < w; b++) begin
                    k = 8 * (big ? w - 1 - b : b);
                    by = 8'($random(seed));
                    if (op < 4'h8)
                        expq.push_back({cif, v[k +: 8]});
                    else begin
                        lq.push_back(by);
                        v[k +: 8] = by;
                    end
                end
                if (sg) v = 32'($signed(v << (32 - 8 * w)) >>> (32 - 8 * w));
                if (op > 4'h8) exps.push_back({id, ix + 16'(i), v});
            end
        end
        @(posedge sys_clk);
        {cmd_op, cmd_if, cmd_type, cmd_id} <= {op, cif, typ, id};
        {cmd_start, cmd_count, dest_defined, cmd_valid} <= {st, cnt, df, 1'b1};
        do @(negedge sys_clk); while (cmd_ready !== 1'b1);
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        @(negedge sys_clk);
        if (late) begin
            repeat (20) @(negedge sys_clk);
            `CHK("early store", 0, stq.size())
        end
        while (lq.size() > 0) peer.rxq.push_back(lq.pop_front());
        for (k = 0; k < 20000 && done !== 1'b1; k++) @(negedge sys_clk);
        `CHK("done", 1'b1, done)
        `CHK("error", err, error)
        if (!err) `CHK("master", 1'b1, master_mode[cif])
        @(negedge sys_clk);
        `CHK("tx count", expq.size(), peer.txq.size())
        for (k = 0; k < expq.size() && k < peer.txq.size(); k++)
            `CHK("tx byte", expq[k], peer.txq[k])
        `CHK("store count", exps.size(), stq.size())
        for (k = 0; k < exps.size() && k < stq.size(); k++)
            `CHK("store", exps[k], stq[k])
        `CHK("host count", exph.size(), hostq.size())
        for (k = 0; k < exph.size() && k < hostq.size(); k++)
            `CHK("host byte", exph[k], hostq[k])
        $display("test op %h if %h type %h ends", op, cif, typ);
        expq.delete();
        peer.txq.delete();
        exps.delete();
        stq.delete();
        exph.delete();
        hostq.delete();
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        #3000000;
        mismatches++;
        give_verdict();
    end
    initial begin
        {arst_n, cmd_valid, late, fetch_last, host_ready} = 5'h00;
        {cmd_op, cmd_if, cmd_type, cmd_id} = 22'h0;
        {cmd_start, cmd_count, dest_defined} = 49'h0;
        fetch_data = 32'h0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (j = 0; j < 8; j++)
            run(4'(j), 2'(j % 3), 8'h08, 32'h3, 1'b1, 1'b0);
        for (j = 0; j < 64; j++)
            run(tops[j / 16], 2'(j % 3), tcode[j % 16], 32'(j % 3), 1'b1, 1'b0);
        for (j = 0; j < 3; j++)
            run(4'h8, 2'(j), 8'h08, 32'h5, 1'b1, 1'b0);
        // caps and a stalled receive
        run(4'h8, 2'h0, 8'h08, 32'h406, 1'b1, 1'b0);
        run(4'h9, 2'h1, 8'h08, 32'h104, 1'b1, 1'b0);
        late = 1'b1;
        run(4'hb, 2'h2, 8'h7b, 32'h2, 1'b1, 1'b0);
        late = 1'b0;
        // refused commands move nothing
        run(4'hc, 2'h0, 8'h10, 32'h2, 1'b0, 1'b1);
        run(4'h5, 2'h1, 8'h6b, 32'h1, 1'b1, 1'b1);
        run(4'hf, 2'h2, 8'h08, 32'h1, 1'b1, 1'b1);
        for (j = 0; j < 60; j++)
            run(4'({$random(seed)} % 13), 2'({$random(seed)} % 3),
                tcode[{$random(seed)} % 16], 32'({$random(seed)} % 6),
                1'b1, 1'b0);
        give_verdict();
    end
endmodule
